// [tb_top.sv]
// Bench: host model issues commands, the bench drives measurements and levels.
// Assumes a retry unit of a few cycles so restart waits stay short.
`timescale 1ns/1ns

module tb_top;
	localparam int UNIT = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bias_ok = 1'b1;
	logic cmd_valid, cmd_write, write_protect, clear_faults, rsp_valid_r, rsp_ack_r, alert_out_n, ack;
	logic [0:0] page_sel;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_rdata_r, rd;
	logic [15:0] output_setpoint_strap = 16'h2000;
	logic [31:0] vout_meas = 32'h0;
	logic [31:0] temp_meas = 32'h0;
	logic [1:0] vout_meas_valid = 2'h0;
	logic [1:0] temp_meas_valid = 2'h0;
	logic [1:0] power_good_flag = 2'h3;
	logic [1:0] output_ramping = 2'h0;
	logic [1:0] output_on_cmd = 2'h3;
	logic [1:0] other_fault_off = 2'h0;
	logic [1:0] output_enable_r, restart_pulse_r, uv_fault_r, ot_fault_r;
	logic [7:0] codes [3] = '{8'h44, 8'h45, 8'h4f};
	logic [15:0] defs [3] = '{16'((32'h2000 * 32'h11) / 32'h14), 16'h0080, 16'hebe8};
	// Threshold below power-good level, action 80h so a stuck output still trips
	logic [15:0] wv [6] = '{16'h1800, 16'h0080, 16'hebe8, 16'h1700, 16'h12f9, 16'hebf8};
	logic [15:0] rv [6] = '{16'h1800, 16'h0080, 16'hebe8, 16'h1700, 16'h00f9, 16'hebf8};
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;

	always #4 clk = ~clk;

	uvot_fault_ctrl #(.NPAGE(2), .PW(1), .RETRY_UNIT_CYC(UNIT)) uvot_fault_ctrl_inst (
		.clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .page_sel, .write_protect, .clear_faults,
		.rsp_valid_r, .rsp_ack_r, .rsp_rdata_r, .output_setpoint_strap, .vout_meas, .vout_meas_valid,
		.temp_meas, .temp_meas_valid, .power_good_flag, .output_ramping, .output_on_cmd, .other_fault_off,
		.bias_ok, .output_enable_r, .restart_pulse_r, .uv_fault_r, .ot_fault_r, .alert_out_n
	);
	uvot_host_model #(.PW(1)) uvot_host_model_inst (
		.clk, .rsp_ack_r, .rsp_rdata_r, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .page_sel,
		.write_protect, .clear_faults
	);

	// ==========
	// Helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (failures == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic sample(input logic temp, input int p, input logic [15:0] v);
		vout_meas[p*16+:16] = v;
		temp_meas[p*16+:16] = v;
		{temp_meas_valid[p], vout_meas_valid[p]} = temp ? 2'h2 : 2'h1;
		@(posedge clk);
		#1 {temp_meas_valid[p], vout_meas_valid[p]} = 2'h0;
		@(posedge clk);
		#1;
	endtask : sample

	function automatic logic [15:0] st();
		return 16'({alert_out_n, output_enable_r, uv_fault_r});
	endfunction : st

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			complete_run();
		end
	end

	// ==========
	// Sequence
	initial begin
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 6; i++) begin
			uvot_host_model_inst.xfer(1'b0, codes[i % 3], 1'(i / 3), 16'h0, 1'b0, ack, rd);
			check("reset_value", rd, defs[i % 3]);
		end
		for (int i = 0; i < 12; i++) begin
			uvot_host_model_inst.xfer(i < 6, codes[i % 3], 1'((i % 6) / 3), wv[i % 6], 1'b0, ack, rd);
			check("ack", 16'(ack), 16'h1);
			if (i >= 6) check("readback", rd, rv[i % 6]);
		end
		uvot_host_model_inst.xfer(1'b1, 8'h44, 1'h0, 16'h0100, 1'b1, ack, rd);
		check("protected_ack", 16'(ack), 16'h0);
		uvot_host_model_inst.xfer(1'b0, 8'h46, 1'h0, 16'h0, 1'b0, ack, rd);
		check("unknown_ack", 16'(ack), 16'h0);
		uvot_host_model_inst.xfer(1'b0, 8'h44, 1'h0, 16'h0, 1'b0, ack, rd);
		check("protected_value", rd, 16'h1800);
		power_good_flag[0] = 1'b0;
		sample(1'b0, 0, 16'h1000);
		power_good_flag[0] = 1'b1;
		output_ramping[0] = 1'b1;
		sample(1'b0, 0, 16'h1000);
		output_ramping[0] = 1'b0;
		sample(1'b0, 0, 16'h1800);
		check("uv_masked", st(), 16'h1c);
		sample(1'b0, 0, 16'h17ff);
		check("uv_hit", st(), 16'h09);
		repeat (40) @(posedge clk);
		#1 uvot_host_model_inst.clear();
		// Output now off, so a low sample must stay unreported
		sample(1'b0, 0, 16'h0100);
		check("uv_no_retry", st(), 16'h18);
		sample(1'b0, 1, 16'h16ff);
		check("retry_off", 16'(output_enable_r), 16'h0);
		n = 0;
		while (restart_pulse_r[1] !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		check("retry_gap", 16'(n >= 2 * UNIT - 2 && n <= 2 * UNIT), 16'h1);
		check("retry_on", 16'(output_enable_r), 16'h2);
		sample(1'b0, 1, 16'h16ff);
		// Another fault during the wait must stop restarts until the output is commanded off
		other_fault_off[1] = 1'b1;
		repeat (30) @(posedge clk);
		#1 check("retry_halt", 16'(output_enable_r), 16'h0);
		other_fault_off[1] = 1'b0;
		output_on_cmd[1] = 1'b0;
		repeat (2) @(posedge clk);
		#1 output_on_cmd[1] = 1'b1;
		repeat (2) @(posedge clk);
		#1 check("halt_exit", 16'(output_enable_r), 16'h2);
		rst = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (2) @(posedge clk);
		#1 check("after_restart", st(), 16'h1c);
		uvot_host_model_inst.xfer(1'b1, 8'h45, 1'h0, 16'h0038, 1'b0, ack, rd);
		sample(1'b0, 0, 16'h1000);
		check("report_only", st(), 16'h0d);
		sample(1'b1, 0, 16'hebe8);
		sample(1'b1, 0, 16'hf1f0);
		check("ot_not_above", 16'(ot_fault_r), 16'h0);
		sample(1'b1, 0, 16'hebf0);
		check("ot_hit", 16'(ot_fault_r), 16'h1);
		uvot_host_model_inst.clear();
		check("cleared", 16'({alert_out_n, ot_fault_r, uv_fault_r}), 16'h10);
		complete_run();
	end
endmodule : tb_top

// [uvot_chk_props.sv]
// Checker for the protection block: command answers, fault status, alert, restart.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns

module uvot_chk_props #(
	parameter int NPAGE = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic write_protect,
	input wire logic clear_faults,
	input wire logic rsp_valid_r,
	input wire logic rsp_ack_r,
	input wire logic [15:0] rsp_rdata_r,
	// Measurement side
	input wire logic [NPAGE-1:0] vout_meas_valid,
	input wire logic [NPAGE-1:0] temp_meas_valid,
	input wire logic [NPAGE-1:0] power_good_flag,
	input wire logic [NPAGE-1:0] output_ramping,
	// Protection outputs
	input wire logic [NPAGE-1:0] output_enable_r,
	input wire logic [NPAGE-1:0] restart_pulse_r,
	input wire logic [NPAGE-1:0] uv_fault_r,
	input wire logic [NPAGE-1:0] ot_fault_r,
	input wire logic alert_out_n
);
	// ==========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_answer_due: assert property (cmd_valid |=> rsp_valid_r)
		else $error("command not answered");
	chk_answer_cause: assert property (rsp_valid_r |-> $past(cmd_valid))
		else $error("answer without command");
	chk_protect_refuse: assert property (cmd_valid && cmd_write && write_protect |=> !rsp_ack_r)
		else $error("protected write accepted");
	chk_code_refuse: assert property (cmd_valid && !(cmd_code inside {8'h44, 8'h45, 8'h4f}) |=>
		!rsp_ack_r && rsp_rdata_r == 16'h0) else $error("unknown code accepted");
	chk_alert_level: assert property (alert_out_n == !(|{uv_fault_r, ot_fault_r}))
		else $error("alert does not follow status");
	chk_uv_hold: assert property (!$past(clear_faults) |-> ($past(uv_fault_r) & ~uv_fault_r) == '0)
		else $error("status dropped without clear");
	chk_uv_masked: assert property ($rose(uv_fault_r[0]) |->
		$past(vout_meas_valid[0] && power_good_flag[0] && !output_ramping[0] && output_enable_r[0]))
		else $error("fault from masked sample");
	chk_ot_sample: assert property ($rose(ot_fault_r[0]) |-> $past(temp_meas_valid[0]))
		else $error("temperature fault without sample");
	chk_restart_edge: assert property (restart_pulse_r[1] |-> output_enable_r[1] && !$past(output_enable_r[1]))
		else $error("restart pulse without enable edge");
	chk_restart_gap: assert property ($fell(output_enable_r[1]) |-> (!output_enable_r[1]) [*3])
		else $error("restart too soon");

	cover property ($rose(uv_fault_r[0]));
	cover property (restart_pulse_r[1]);
	cover property (cmd_valid && cmd_write && write_protect);
endmodule : uvot_chk_props

bind uvot_fault_ctrl uvot_chk_props #(.NPAGE(NPAGE)) uvot_chk_props_inst (
	.clk, .rst, .cmd_valid, .cmd_write, .cmd_code, .write_protect, .clear_faults, .rsp_valid_r, .rsp_ack_r,
	.rsp_rdata_r, .vout_meas_valid, .temp_meas_valid, .power_good_flag, .output_ramping, .output_enable_r,
	.restart_pulse_r, .uv_fault_r, .ot_fault_r, .alert_out_n
);

// [uvot_fault_ctrl.sv]
// Output undervoltage and over-temperature protection for a multi-output
// power stage: paged settings, fault detection, latched status, alert and
// the restart sequencer. Assumes one clock; the command port, measurements
// and control levels are synchronous to it.
`timescale 1ns/1ns
`include "uvot_map.svh"

module uvot_fault_ctrl
	import uvot_pkg::*;
#(
	parameter int NPAGE = 2,
	parameter int PW = 1,
	parameter int unsigned RETRY_UNIT_CYC = `UVOT_RETRY_UNIT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Management command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [PW-1:0] page_sel,
	input wire logic write_protect,
	input wire logic clear_faults,
	output logic rsp_valid_r,
	output logic rsp_ack_r,
	output logic [15:0] rsp_rdata_r,
	// Strap
	input wire logic [15:0] output_setpoint_strap,
	// Per-output measurements and state, and the shared bias_ok level
	input wire logic [NPAGE*16-1:0] vout_meas,
	input wire logic [NPAGE-1:0] vout_meas_valid,
	input wire logic [NPAGE*16-1:0] temp_meas,
	input wire logic [NPAGE-1:0] temp_meas_valid,
	input wire logic [NPAGE-1:0] power_good_flag,
	input wire logic [NPAGE-1:0] output_ramping,
	input wire logic [NPAGE-1:0] output_on_cmd,
	input wire logic [NPAGE-1:0] other_fault_off,
	input wire logic bias_ok,
	// Protection outputs
	output logic [NPAGE-1:0] output_enable_r,
	output logic [NPAGE-1:0] restart_pulse_r,
	output logic [NPAGE-1:0] uv_fault_r,
	output logic [NPAGE-1:0] ot_fault_r,
	output logic alert_out_n
);

	// ======================================================================
	// Helpers
	// Linear-11 to signed fixed point, scaled by 2^16 so the exponent
	// range -16..15 always shifts left and no fraction is lost.
	function automatic logic signed [47:0] lin11_fix(input logic [15:0] w);
		logic signed [5:0] expo;
		logic signed [47:0] man;
		logic [5:0] sh;
		expo = 6'($signed(w[`UVOT_L11_EXP_HI:`UVOT_L11_EXP_LO]));
		man = 48'($signed(w[`UVOT_L11_MAN_HI:`UVOT_L11_MAN_LO]));
		sh = 6'(expo + `UVOT_L11_BIAS);
		lin11_fix = man <<< sh;
	endfunction : lin11_fix

	function automatic uvot_sel_t code_sel(input logic [7:0] code);
		case (code)
			`UVOT_CMD_UV_THR: code_sel = UVOT_SEL_UV_THR;
			`UVOT_CMD_UV_ACT: code_sel = UVOT_SEL_UV_ACT;
			`UVOT_CMD_OT_THR: code_sel = UVOT_SEL_OT_THR;
			default: code_sel = UVOT_SEL_NONE;
		endcase
	endfunction : code_sel

	// ======================================================================
	// Command decode
	uvot_sel_t sel;
	logic page_ok;
	logic wr_go;
	logic [NPAGE*16-1:0] uv_thr_flat;
	logic [NPAGE*8-1:0] uv_act_flat;
	logic [NPAGE*16-1:0] ot_thr_flat;

	assign sel = code_sel(cmd_code);
	assign page_ok = (32'(page_sel) < 32'(NPAGE));
	// Protected writes are refused outright, stored copy untouched
	assign wr_go = cmd_valid && cmd_write && sel != UVOT_SEL_NONE && page_ok && !write_protect;

	uvot_page_store #(
		.NPAGE(NPAGE),
		.PW(PW)
	) u_store (
		.clk(clk),
		.rst(rst),
		.output_setpoint_strap(output_setpoint_strap),
		.wr_en(wr_go),
		.wr_page(page_sel),
		.wr_sel(sel),
		.wr_data(cmd_wdata),
		.uv_thr_flat(uv_thr_flat),
		.uv_act_flat(uv_act_flat),
		.ot_thr_flat(ot_thr_flat)
	);

	// ======================================================================
	// Command answer, one cycle after the request
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0000;
		if (page_ok) begin
			case (sel)
				UVOT_SEL_UV_THR: rd_mux = uv_thr_flat[32'(page_sel)*16 +: 16];
				UVOT_SEL_UV_ACT: rd_mux = {8'h00, uv_act_flat[32'(page_sel)*8 +: 8]};
				UVOT_SEL_OT_THR: rd_mux = ot_thr_flat[32'(page_sel)*16 +: 16];
				default: rd_mux = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid_r <= 1'b0;
			rsp_ack_r <= 1'b0;
			rsp_rdata_r <= 16'h0000;
		end else begin
			rsp_valid_r <= cmd_valid;
			if (cmd_valid) begin
				rsp_ack_r <= cmd_write ? wr_go : (sel != UVOT_SEL_NONE && page_ok);
				rsp_rdata_r <= cmd_write ? 16'h0000 : rd_mux;
			end
		end
	end

	// ======================================================================
	// Per-output detection and restart sequencer
	logic [NPAGE-1:0] uv_hit;
	logic [NPAGE-1:0] ot_hit;

	genvar p;
	generate
		for (p = 0; p < NPAGE; p++) begin : g_out
			uvot_state_t st_r;
			uvot_state_t st_nxt;
			logic [31:0] tmr_r;
			logic [7:0] act;
			logic [1:0] mode;
			logic [2:0] retry;
			logic [31:0] wait_cyc;
			logic armed;
			logic stop;

			assign act = uv_act_flat[p*8 +: 8];
			assign mode = act[`UVOT_ACT_MODE_HI:`UVOT_ACT_MODE_LO];
			assign retry = act[`UVOT_ACT_RETRY_HI:`UVOT_ACT_RETRY_LO];
			// Delay range 1..8 units, so no overflow at 32 bits
			assign wait_cyc = 32'((32'(act[`UVOT_ACT_DLY_HI:`UVOT_ACT_DLY_LO]) + 32'd1) * RETRY_UNIT_CYC);

			// Masked while ramping, before power-good or while off
			assign armed = output_enable_r[p] && power_good_flag[p] && !output_ramping[p];
			assign uv_hit[p] = armed && vout_meas_valid[p] && (vout_meas[p*16 +: 16] < uv_thr_flat[p*16 +: 16]);
			assign ot_hit[p] = temp_meas_valid[p] &&
				(lin11_fix(temp_meas[p*16 +: 16]) > lin11_fix(ot_thr_flat[p*16 +: 16]));
			assign stop = !output_on_cmd[p] || !bias_ok || other_fault_off[p];

			always_comb begin
				st_nxt = st_r;
				case (st_r)
					UVOT_ST_RUN: begin
						if (uv_hit[p] && (mode == `UVOT_MODE_SHUT_A || mode == `UVOT_MODE_SHUT_B)) begin
							if (retry == `UVOT_RETRY_CONT) begin
								st_nxt = UVOT_ST_WAIT;
							end else begin
								// Unused retry codes behave as no retry
								st_nxt = UVOT_ST_LATCH;
							end
						end
					end
					UVOT_ST_WAIT: begin
						if (stop) begin
							st_nxt = UVOT_ST_HALT;
						end else if (tmr_r == 32'd1) begin
							st_nxt = UVOT_ST_RUN;
						end
					end
					UVOT_ST_LATCH: st_nxt = UVOT_ST_LATCH;
					UVOT_ST_HALT: begin
						// Normal control resumes once commanded off
						if (!output_on_cmd[p]) begin
							st_nxt = UVOT_ST_RUN;
						end
					end
					default: st_nxt = UVOT_ST_LATCH;
				endcase
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					st_r <= UVOT_ST_RUN;
				end else begin
					st_r <= st_nxt;
				end
			end

			// Timer loads on entry to the wait, counts down to the restart
			always_ff @(posedge clk) begin
				if (rst) begin
					tmr_r <= 32'd0;
				end else if (st_r != UVOT_ST_WAIT && st_nxt == UVOT_ST_WAIT) begin
					tmr_r <= wait_cyc;
				end else if (st_r == UVOT_ST_WAIT && tmr_r != 32'd0) begin
					tmr_r <= tmr_r - 32'd1;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					output_enable_r[p] <= 1'b0;
					restart_pulse_r[p] <= 1'b0;
				end else begin
					output_enable_r[p] <= (st_nxt == UVOT_ST_RUN) && output_on_cmd[p] && bias_ok;
					restart_pulse_r[p] <= (st_r == UVOT_ST_WAIT) && (st_nxt == UVOT_ST_RUN);
				end
			end

			// Set wins over a clear arriving in the same cycle
			always_ff @(posedge clk) begin
				if (rst) begin
					uv_fault_r[p] <= 1'b0;
					ot_fault_r[p] <= 1'b0;
				end else begin
					if (uv_hit[p]) begin
						uv_fault_r[p] <= 1'b1;
					end else if (clear_faults) begin
						uv_fault_r[p] <= 1'b0;
					end
					if (ot_hit[p]) begin
						ot_fault_r[p] <= 1'b1;
					end else if (clear_faults) begin
						ot_fault_r[p] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ======================================================================
	// Alert, low while any fault bit is latched or being set
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_out_n <= 1'b1;
		end else begin
			alert_out_n <= ~(|uv_hit | |ot_hit | (|uv_fault_r & ~clear_faults) | (|ot_fault_r & ~clear_faults));
		end
	end

endmodule : uvot_fault_ctrl

// [uvot_host_model.sv]
// Host side of the command port: one command at a time, clear-faults pulses.
// Assumes callers enter just after a rising clock edge.
`timescale 1ns/1ns

module uvot_host_model #(
	parameter int PW = 1
) (
	// Clock and answer
	input wire logic clk,
	input wire logic rsp_ack_r,
	input wire logic [15:0] rsp_rdata_r,
	// Requests
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic [PW-1:0] page_sel,
	output logic write_protect,
	output logic clear_faults
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h0;
		cmd_wdata = 16'h0;
		page_sel = '0;
		write_protect = 1'b0;
		clear_faults = 1'b0;
	end

	task automatic xfer(input logic wr, input logic [7:0] code, input logic [PW-1:0] pg, input logic [15:0] wd,
		input logic wp, output logic ack, output logic [15:0] rd);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = wd;
		page_sel = pg;
		write_protect = wp;
		@(posedge clk);
		#1 ack = rsp_ack_r;
		rd = rsp_rdata_r;
		cmd_valid = 1'b0;
		// Released lines must not look like the last value
		cmd_code = ~code;
		cmd_wdata = ~wd;
		@(posedge clk);
		#1;
	endtask : xfer

	task automatic clear();
		clear_faults = 1'b1;
		@(posedge clk);
		#1 clear_faults = 1'b0;
		@(posedge clk);
		#1;
	endtask : clear
endmodule : uvot_host_model

// [uvot_map.svh]
// Command codes, field positions, reset values and timing figures of the
// undervoltage / over-temperature protection block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef UVOT_MAP_SVH
`define UVOT_MAP_SVH

// ==========================================================================
// Command codes (paged settings)
`define UVOT_CMD_UV_THR 8'h44
`define UVOT_CMD_UV_ACT 8'h45
`define UVOT_CMD_OT_THR 8'h4f

// ==========================================================================
// Reset values
`define UVOT_UV_ACT_RST 8'h80
`define UVOT_OT_THR_RST 16'hebe8
// Undervoltage default is strap code scaled by 17/20 (0.85)
`define UVOT_UV_SCALE_NUM 32'd17
`define UVOT_UV_SCALE_DEN 32'd20

// ==========================================================================
// Action field layout
`define UVOT_ACT_MODE_HI 7
`define UVOT_ACT_MODE_LO 6
`define UVOT_ACT_RETRY_HI 5
`define UVOT_ACT_RETRY_LO 3
`define UVOT_ACT_DLY_HI 2
`define UVOT_ACT_DLY_LO 0
`define UVOT_MODE_SHUT_A 2'b10
`define UVOT_MODE_SHUT_B 2'b11
`define UVOT_RETRY_NONE 3'b000
`define UVOT_RETRY_CONT 3'b111

// ==========================================================================
// Linear-11 layout
`define UVOT_L11_EXP_HI 15
`define UVOT_L11_EXP_LO 11
`define UVOT_L11_MAN_HI 10
`define UVOT_L11_MAN_LO 0
`define UVOT_L11_BIAS 6'sd16

// ==========================================================================
// Timing
`define UVOT_CLK_MHZ 125
`define UVOT_RETRY_UNIT_MS 35
`define UVOT_RETRY_UNIT_CYC (`UVOT_RETRY_UNIT_MS * `UVOT_CLK_MHZ * 1000)

`endif

// [uvot_page_store.sv]
// Per-output copies of the undervoltage threshold, undervoltage action and
// over-temperature threshold. Assumes a single clock and synchronous reset;
// the strap is stable around reset release.
`timescale 1ns/1ns
`include "uvot_map.svh"

module uvot_page_store
	import uvot_pkg::*;
#(
	parameter int NPAGE = 2,
	parameter int PW = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Setpoint strap, linear-16 code
	input wire logic [15:0] output_setpoint_strap,
	// Write port
	input wire logic wr_en,
	input wire logic [PW-1:0] wr_page,
	input wire uvot_sel_t wr_sel,
	input wire logic [15:0] wr_data,
	// Stored settings, page p in slice p
	output logic [NPAGE*16-1:0] uv_thr_flat,
	output logic [NPAGE*8-1:0] uv_act_flat,
	output logic [NPAGE*16-1:0] ot_thr_flat
);

	// ======================================================================
	// Strap capture
	// Loaded one cycle after release, never under reset itself
	logic strap_pend_r;
	logic [15:0] uv_dflt;
	logic [31:0] uv_prod;

	assign uv_prod = (32'(output_setpoint_strap) * `UVOT_UV_SCALE_NUM) / `UVOT_UV_SCALE_DEN;
	assign uv_dflt = uv_prod[15:0];

	always_ff @(posedge clk) begin
		if (rst) begin
			strap_pend_r <= 1'b1;
		end else begin
			strap_pend_r <= 1'b0;
		end
	end

	// ======================================================================
	// Setting registers, one set per page
	genvar p;
	generate
		for (p = 0; p < NPAGE; p++) begin : g_page
			logic [15:0] uv_thr_r;
			logic [7:0] uv_act_r;
			logic [15:0] ot_thr_r;
			logic hit;

			assign hit = wr_en && (wr_page == PW'(p));

			always_ff @(posedge clk) begin
				if (rst) begin
					uv_thr_r <= 16'h0000;
				end else if (hit && wr_sel == UVOT_SEL_UV_THR) begin
					uv_thr_r <= wr_data;
				end else if (strap_pend_r) begin
					uv_thr_r <= uv_dflt;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					uv_act_r <= `UVOT_UV_ACT_RST;
				end else if (hit && wr_sel == UVOT_SEL_UV_ACT) begin
					uv_act_r <= wr_data[7:0];
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					ot_thr_r <= `UVOT_OT_THR_RST;
				end else if (hit && wr_sel == UVOT_SEL_OT_THR) begin
					ot_thr_r <= wr_data;
				end
			end

			assign uv_thr_flat[p*16 +: 16] = uv_thr_r;
			assign uv_act_flat[p*8 +: 8] = uv_act_r;
			assign ot_thr_flat[p*16 +: 16] = ot_thr_r;
		end
	endgenerate

endmodule : uvot_page_store

// [uvot_pkg.sv]
// Types shared by the undervoltage / over-temperature protection block.
// Assumes uvot_map.svh for all numeric constants.
package uvot_pkg;

	// ======================================================================
	// Per-output restart sequencer states, one-hot
	typedef enum logic [3:0] {
		UVOT_ST_RUN = 4'b0001,
		UVOT_ST_WAIT = 4'b0010,
		UVOT_ST_LATCH = 4'b0100,
		UVOT_ST_HALT = 4'b1000
	} uvot_state_t;

	// ======================================================================
	// Which paged setting a command addresses
	typedef enum logic [1:0] {
		UVOT_SEL_NONE = 2'b00,
		UVOT_SEL_UV_THR = 2'b01,
		UVOT_SEL_UV_ACT = 2'b10,
		UVOT_SEL_OT_THR = 2'b11
	} uvot_sel_t;

endpackage : uvot_pkg
